// file: shared/pioc_defs.svh
`ifndef PIOC_DEFS_SVH
`define PIOC_DEFS_SVH
// Register byte offsets
`define PIOC_LINE_OWNER_ENABLE     8'h00
`define PIOC_LINE_OWNER_DISABLE    8'h04
`define PIOC_LINE_OWNER_STATUS     8'h08
`define PIOC_OUTPUT_ENABLE_SET     8'h10
`define PIOC_OUTPUT_ENABLE_CLEAR   8'h14
`define PIOC_OUTPUT_ENABLE_STATUS  8'h18
`define PIOC_GLITCH_FILTER_SET     8'h20
`define PIOC_GLITCH_FILTER_CLEAR   8'h24
`define PIOC_GLITCH_FILTER_STATUS  8'h28
`define PIOC_OUTPUT_LEVEL_SET      8'h30
`define PIOC_OUTPUT_LEVEL_CLEAR    8'h34
`define PIOC_OUTPUT_LEVEL_STATUS   8'h38
`define PIOC_PIN_LEVEL_STATUS      8'h3c
`define PIOC_CHANGE_IRQ_ENABLE     8'h40
`define PIOC_CHANGE_IRQ_DISABLE    8'h44
`define PIOC_CHANGE_IRQ_MASK       8'h48
`define PIOC_CHANGE_IRQ_STATUS     8'h4c
`define PIOC_OPEN_DRAIN_SET        8'h50
`define PIOC_OPEN_DRAIN_CLEAR      8'h54
`define PIOC_OPEN_DRAIN_STATUS     8'h58
`define PIOC_PULLUP_OFF            8'h60
`define PIOC_PULLUP_ON             8'h64
`define PIOC_PULLUP_STATUS         8'h68
`define PIOC_PERIPH_FIRST_SELECT   8'h70
`define PIOC_PERIPH_SECOND_SELECT  8'h74
`define PIOC_PERIPH_SELECT_STATUS  8'h78
`define PIOC_DIRECT_WRITE_ENABLE   8'ha0
`define PIOC_DIRECT_WRITE_DISABLE  8'ha4
`define PIOC_DIRECT_WRITE_STATUS   8'ha8
// Reset values
`define PIOC_RST_ZERO              32'h00000000
`define PIOC_RST_OWNER             32'hffffffff
`define PIOC_RST_IMPL              32'hffffffff
`define PIOC_RST_MUXED             32'hffffffff
`endif

// file: shared/pioc_pkg.sv
`default_nettype none
package pioc_pkg;
    typedef logic [31:0] pioc_word_t;
endpackage
`default_nettype wire

// file: logic/pioc_glitch_filter.sv
`include "pioc_defs.svh"
`default_nettype none
module pioc_glitch_filter #(
    parameter int unsigned LINES = 32
) (
    input  wire logic             clk,      // Master clock
    input  wire logic             rst,      // Async reset, high
    input  wire logic [LINES-1:0] pin_in,   // Raw pin levels
    input  wire logic [LINES-1:0] filt_en,  // Per-line filter enable
    output logic      [LINES-1:0] level_out // Resolved level per line
);
    // Per-line results gathered on a net, then handed out as one word
    wire logic [LINES-1:0] level_w;
    genvar i;
    generate
        for (i = 0; i < LINES; i = i + 1)
        begin : g_line
            logic fall_smp;
            logic rise_smp;
            logic filt_reg;
            logic filt_next;
            // Half-cycle sample on falling edge
            always_ff @(negedge clk or posedge rst)
            begin
                if (rst)
                    fall_smp <= 1'b0;
                else
                    fall_smp <= pin_in[i];
            end
            // Raw sample on rising edge
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    rise_smp <= 1'b0;
                else
                    rise_smp <= pin_in[i];
            end
            // Level must be seen at both edges before accepted
            assign filt_next = (fall_smp == pin_in[i]) ? pin_in[i] : filt_reg;
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    filt_reg <= 1'b0;
                else
                    filt_reg <= filt_next;
            end
            assign level_w[i] = filt_en[i] ? filt_reg : rise_smp;
        end
    endgenerate
    assign level_out = level_w;
endmodule
`default_nettype wire

// file: logic/pioc_line_controller.sv
`include "pioc_defs.svh"
`default_nettype none
module pioc_line_controller #(
    parameter logic [31:0] IMPL_MASK  = `PIOC_RST_IMPL,  // Lines that exist
    parameter logic [31:0] MUXED_MASK = `PIOC_RST_MUXED, // Lines with peripherals
    parameter logic [31:0] OWNER_RST  = `PIOC_RST_OWNER  // Owner status reset
) (
    input  wire logic        clk,        // Master clock
    input  wire logic        rst,        // Async reset, high
    input  wire logic        psel,       // APB select
    input  wire logic        penable,    // APB enable
    input  wire logic        pwrite,     // APB write
    input  wire logic [7:0]  paddr,      // APB byte address
    input  wire logic [31:0] pwdata,     // APB write data
    output logic      [31:0] prdata,     // APB read data
    output logic             pready,     // APB ready
    output logic             pslverr,    // APB error
    input  wire logic [31:0] pin_in,     // Pad input levels
    output logic      [31:0] pin_out,    // Pad output level
    output logic      [31:0] pin_oe,     // Pad output enable
    output logic      [31:0] pullup_en,  // Pad pull-up enable
    input  wire logic [31:0] per_a_out,  // Peripheral A output
    input  wire logic [31:0] per_a_oe,   // Peripheral A enable
    input  wire logic [31:0] per_b_out,  // Peripheral B output
    input  wire logic [31:0] per_b_oe,   // Peripheral B enable
    output logic      [31:0] per_in,     // Unfiltered input to peripherals
    output logic             irq         // Combined change interrupt
);
    pioc_pkg::pioc_word_t owner_reg, oe_reg, filt_reg, odata_reg, imask_reg;
    pioc_pkg::pioc_word_t istat_reg, md_reg, puoff_reg, absel_reg, ow_reg;
    pioc_pkg::pioc_word_t owner_next, oe_next, filt_next, odata_next, imask_next;
    pioc_pkg::pioc_word_t istat_next, md_next, puoff_next, absel_next, ow_next;
    pioc_pkg::pioc_word_t level, level_reg, wd, rd_mux;
    pioc_pkg::pioc_word_t drv_oe, pad_out, pad_oe;
    logic                 wr, rd, ack_reg;
    logic                 level_valid_reg;
    logic                 isr_clr;
    logic                 odata_wr;
    logic                 sel_owner_st;
    logic                 sel_oe_st;
    logic                 sel_filt_st;
    logic                 sel_odata_st;
    logic                 sel_pin_st;
    logic                 sel_imask_st;
    logic                 sel_istat_st;
    logic                 sel_md_st;
    logic                 sel_pu_st;
    logic                 sel_absel_st;
    logic                 sel_ow_st;

    // Bus strobes; one wait state per transfer
    assign wr = psel & penable & pwrite & ~ack_reg;
    assign rd = psel & penable & ~pwrite & ~ack_reg;
    assign wd = pwdata & IMPL_MASK;

    // Status and data register address matches
    assign sel_owner_st = (paddr == `PIOC_LINE_OWNER_STATUS);
    assign sel_oe_st    = (paddr == `PIOC_OUTPUT_ENABLE_STATUS);
    assign sel_filt_st  = (paddr == `PIOC_GLITCH_FILTER_STATUS);
    assign sel_odata_st = (paddr == `PIOC_OUTPUT_LEVEL_STATUS);
    assign sel_pin_st   = (paddr == `PIOC_PIN_LEVEL_STATUS);
    assign sel_imask_st = (paddr == `PIOC_CHANGE_IRQ_MASK);
    assign sel_istat_st = (paddr == `PIOC_CHANGE_IRQ_STATUS);
    assign sel_md_st    = (paddr == `PIOC_OPEN_DRAIN_STATUS);
    assign sel_pu_st    = (paddr == `PIOC_PULLUP_STATUS);
    assign sel_absel_st = (paddr == `PIOC_PERIPH_SELECT_STATUS);
    assign sel_ow_st    = (paddr == `PIOC_DIRECT_WRITE_STATUS);

    // Strobes acting on a status register itself; taken at first access edge
    assign isr_clr  = rd & sel_istat_st;
    assign odata_wr = wr & sel_odata_st;

    // Write decode helpers
    function automatic pioc_pkg::pioc_word_t hit(input logic [7:0] off);
        hit = (wr && paddr == off) ? wd : 32'h00000000;
    endfunction

    // Set/clear pairs; zero bits leave status unchanged
    assign owner_next = ((owner_reg | hit(`PIOC_LINE_OWNER_ENABLE))
                        & ~hit(`PIOC_LINE_OWNER_DISABLE)) | ~MUXED_MASK;
    assign oe_next    = (oe_reg | hit(`PIOC_OUTPUT_ENABLE_SET))
                        & ~hit(`PIOC_OUTPUT_ENABLE_CLEAR);
    assign filt_next  = (filt_reg | hit(`PIOC_GLITCH_FILTER_SET))
                        & ~hit(`PIOC_GLITCH_FILTER_CLEAR);
    assign imask_next = (imask_reg | hit(`PIOC_CHANGE_IRQ_ENABLE))
                        & ~hit(`PIOC_CHANGE_IRQ_DISABLE);
    assign md_next    = (md_reg | hit(`PIOC_OPEN_DRAIN_SET))
                        & ~hit(`PIOC_OPEN_DRAIN_CLEAR);
    assign puoff_next = (puoff_reg | hit(`PIOC_PULLUP_OFF))
                        & ~hit(`PIOC_PULLUP_ON);
    assign absel_next = (absel_reg | hit(`PIOC_PERIPH_SECOND_SELECT))
                        & ~hit(`PIOC_PERIPH_FIRST_SELECT);
    assign ow_next    = (ow_reg | hit(`PIOC_DIRECT_WRITE_ENABLE))
                        & ~hit(`PIOC_DIRECT_WRITE_DISABLE);

    // Output data: set/clear plus masked direct write
    assign odata_next = (((odata_reg | hit(`PIOC_OUTPUT_LEVEL_SET))
                        & ~hit(`PIOC_OUTPUT_LEVEL_CLEAR))
                        & ~(ow_reg & {32{odata_wr}}))
                        | (hit(`PIOC_OUTPUT_LEVEL_STATUS) & ow_reg);

    // Change detection; new change wins over read clear
    assign istat_next = (isr_clr ? 32'h00000000 : istat_reg)
                        | ((level ^ level_reg) & IMPL_MASK
                           & {32{level_valid_reg}});

    // Per-line input filtering
    pioc_glitch_filter #(
        .LINES     (32)
    ) u_filter (
        .clk       (clk),
        .rst       (rst),
        .pin_in    (pin_in),
        .filt_en   (filt_reg),
        .level_out (level)
    );

    // Output path selection
    assign pad_out = (owner_reg & odata_reg)
                     | (~owner_reg & ~absel_reg & per_a_out)
                     | (~owner_reg & absel_reg & per_b_out);
    assign drv_oe  = (owner_reg & oe_reg)
                     | (~owner_reg & ~absel_reg & per_a_oe)
                     | (~owner_reg & absel_reg & per_b_oe);
    // Open drain drives only low
    assign pad_oe  = drv_oe & ~(md_reg & pad_out);

    // Read multiplexer; unmapped offsets read zero
    always_comb
    begin
        if (sel_owner_st)
            rd_mux = owner_reg & IMPL_MASK;
        else if (sel_oe_st)
            rd_mux = oe_reg;
        else if (sel_filt_st)
            rd_mux = filt_reg;
        else if (sel_odata_st)
            rd_mux = odata_reg;
        else if (sel_pin_st)
            rd_mux = level_reg & IMPL_MASK;
        else if (sel_imask_st)
            rd_mux = imask_reg;
        else if (sel_istat_st)
            rd_mux = istat_reg;
        else if (sel_md_st)
            rd_mux = md_reg;
        else if (sel_pu_st)
            rd_mux = puoff_reg;
        else if (sel_absel_st)
            rd_mux = absel_reg;
        else if (sel_ow_st)
            rd_mux = ow_reg;
        else
            rd_mux = 32'h00000000;
    end

    // Line ownership; unmuxed lines read owned even straight after reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            owner_reg <= OWNER_RST | ~MUXED_MASK;
        else
            owner_reg <= owner_next;
    end

    // Output enable status
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            oe_reg <= `PIOC_RST_ZERO;
        else
            oe_reg <= oe_next;
    end

    // Glitch filter enables
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            filt_reg <= `PIOC_RST_ZERO;
        else
            filt_reg <= filt_next;
    end

    // Output data level
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            odata_reg <= `PIOC_RST_ZERO;
        else
            odata_reg <= odata_next;
    end

    // Change interrupt mask
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            imask_reg <= `PIOC_RST_ZERO;
        else
            imask_reg <= imask_next;
    end

    // Open drain status
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            md_reg <= `PIOC_RST_ZERO;
        else
            md_reg <= md_next;
    end

    // Pull-up off status
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            puoff_reg <= `PIOC_RST_ZERO;
        else
            puoff_reg <= puoff_next;
    end

    // Peripheral B select status
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            absel_reg <= `PIOC_RST_ZERO;
        else
            absel_reg <= absel_next;
    end

    // Direct write mask
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ow_reg <= `PIOC_RST_ZERO;
        else
            ow_reg <= ow_next;
    end

    // Previous level sample for the change compare
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            level_reg <= `PIOC_RST_ZERO;
        else
            level_reg <= level;
    end

    // No reference sample yet right after reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            level_valid_reg <= 1'b0;
        else
            level_valid_reg <= 1'b1;
    end

    // Change status; a change in the clearing cycle is kept
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            istat_reg <= `PIOC_RST_ZERO;
        else
            istat_reg <= istat_next;
    end

    // APB answer: one wait state, ready and data stand one cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ack_reg <= 1'b0;
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            ack_reg <= psel & penable & ~ack_reg;
            pready  <= psel & penable & ~ack_reg;
            prdata  <= rd ? rd_mux : 32'h00000000;
            pslverr <= 1'b0;
        end
    end

    // Pad drive, one cycle behind register state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_out <= 32'h00000000;
            pin_oe  <= 32'h00000000;
        end
        else
        begin
            pin_out <= pad_out & IMPL_MASK;
            pin_oe  <= pad_oe & IMPL_MASK;
        end
    end

    // Pull-ups and the raw peripheral input copy
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pullup_en <= 32'h00000000;
            per_in    <= 32'h00000000;
        end
        else
        begin
            pullup_en <= ~puoff_reg & IMPL_MASK;
            per_in    <= pin_in;
        end
    end

    // Interrupt uses next status so it rises with the status bit
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(istat_next & imask_next);
    end
endmodule
`default_nettype wire

// file: dv/pioc_line_controller_sva.sv
`default_nettype none
module pioc_chk #(
    parameter logic [31:0] IMPL_MASK = 32'hffffffff
) (
    input wire logic        clk,       // Clock
    input wire logic        rst,       // Reset
    input wire logic        psel,      // Select
    input wire logic        penable,   // Enable
    input wire logic        pwrite,    // Write
    input wire logic [7:0]  paddr,     // Address
    input wire logic [31:0] pwdata,    // Write data
    input wire logic [31:0] prdata,    // Read data
    input wire logic        pready,    // Ready
    input wire logic        pslverr,   // Error
    input wire logic [31:0] pin_in,    // Pad level
    input wire logic [31:0] pin_oe,    // Pad enable
    input wire logic [31:0] pullup_en, // Pull-up on
    input wire logic [31:0] per_in,    // Periph input
    input wire logic        irq        // Interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Write taking effect at this edge, status read
    wire wr = psel & penable & pwrite & ~pready;
    wire rd_isr = pready & ~pwrite & (paddr == 8'h4c);
    sequence s_acc; psel && penable && !pready; endsequence
    sequence s_ans; pready ##1 !pready; endsequence
    sequence s_quiet; $stable(pin_in) [*6]; endsequence
    property p_answer; s_acc |=> s_ans; endproperty
    property p_no_err; pready |-> !pslverr; endproperty
    property p_rd_impl; pready && !pwrite |-> (prdata & ~IMPL_MASK) == 32'h0; endproperty
    property p_irq_stat; s_quiet ##0 (rd_isr && prdata == 32'h0) |-> !irq; endproperty
    property p_isr_clr; s_quiet ##0 rd_isr |=> !irq [*2]; endproperty
    property p_per_in; !$past(rst) |-> per_in == $past(pin_in); endproperty
    property p_pu_off;
        wr && paddr == 8'h60 |-> ##2 (pullup_en & $past(pwdata, 2) & IMPL_MASK) == 32'h0;
    endproperty
    property p_pu_on;
        wr && paddr == 8'h64 |-> ##2 (pullup_en & $past(pwdata, 2))
            == ($past(pwdata, 2) & IMPL_MASK);
    endproperty
    property p_irq_off; wr && paddr == 8'h44 && pwdata == 32'hffffffff |-> ##2 !irq [*2];
    endproperty
    property p_oe_impl; (pin_oe & ~IMPL_MASK) == 32'h0; endproperty
    a_answer: assert property (p_answer) else $error("ready late or long");
    a_no_err: assert property (p_no_err) else $error("error flagged");
    a_rd_impl: assert property (p_rd_impl) else $error("absent line read");
    a_irq_stat: assert property (p_irq_stat) else $error("irq no status");
    a_isr_clr: assert property (p_isr_clr) else $error("irq after clear");
    a_per_in: assert property (p_per_in) else $error("periph input");
    a_pu_off: assert property (p_pu_off) else $error("pull-up stays on");
    a_pu_on: assert property (p_pu_on) else $error("pull-up stays off");
    a_irq_off: assert property (p_irq_off) else $error("masked irq");
    a_oe_impl: assert property (p_oe_impl) else $error("absent line driven");
endmodule
bind pioc_line_controller pioc_chk #(.IMPL_MASK(IMPL_MASK)) chk (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .per_in(per_in), .irq(irq));
`default_nettype wire

// file: dv/pioc_pad_model.sv
`default_nettype none
module pioc_pad_model (
    input  wire logic        clk,     // Clock
    input  wire logic [31:0] ext_lvl, // Outside drive
    input  wire logic [31:0] pin_out, // Pad drive
    input  wire logic [31:0] pin_oe,  // Pad enable
    output logic      [31:0] pin_in,  // Pad level
    output logic      [31:0] pa,      // Periph A data
    output logic      [31:0] pb,      // Periph B data
    output logic      [31:0] poe      // Periph enables
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] glitch = 32'h0;
    // Peripherals drive opposite fixed patterns
    assign pa = 32'h55555555;
    assign pb = 32'haaaaaaaa;
    assign poe = 32'hffffffff;
    // Driven lines follow the design, the rest the outside world
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & (ext_lvl ^ glitch));
    // Pulse of w ns centred on the next rising edge
    task automatic pulse(input logic [31:0] m, input int w);
        @(posedge clk);
        #(40 - w / 2) glitch = m;
        #(w) glitch = 32'h0;
    endtask
endmodule
`default_nettype wire

// file: dv/test_parallel_io_line_controller.sv
`default_nettype none
module test_parallel_io_line_controller;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] IMPL = 32'h3fffffff;
    localparam logic [31:0] MUXED = 32'h00ffffff;
    localparam logic [31:0] ORST = 32'hffff0000;
    localparam logic [7:0] SETA [9] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60,
        8'h74, 8'ha0};
    localparam logic [7:0] CLRA [9] = '{8'h04, 8'h14, 8'h24, 8'h34, 8'h44, 8'h54, 8'h64,
        8'h70, 8'ha4};
    logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, ext_lvl = 32'h0, rd;
    logic [31:0] prdata, pin_in, pin_out, pin_oe, pullup_en, pa, pb, poe, per_in;
    logic pready, pslverr, irq;
    int err_total = 0, checks = 0, cyc = 0;
    pioc_line_controller #(.IMPL_MASK(IMPL), .MUXED_MASK(MUXED), .OWNER_RST(ORST)) uut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .per_a_out(pa), .per_a_oe(poe), .per_b_out(pb),
        .per_b_oe(poe), .per_in(per_in), .irq(irq));
    pioc_pad_model pad (.clk(clk), .ext_lvl(ext_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_in(pin_in), .pa(pa), .pb(pb), .poe(poe));
    initial forever #20 clk = ~clk;
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            wrap_up();
        end
    end
    task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s exp %h got %h", n, exp, got);
        end
    endtask
    // One bus transfer, held until ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'h1);
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    function automatic logic [31:0] fix(input int i, input logic [31:0] v);
        return (i == 0) ? ((v | ~MUXED) & IMPL) : (v & IMPL);
    endfunction
    task automatic t_pairs;
        logic [7:0] s;
        for (int i = 0; i < 9; i++)
        begin
            s = (SETA[i] | CLRA[i]) + 8'h4;
            apb(1'h0, s, 32'h0);
            check("reset", rd, fix(i, (i == 0) ? ORST : 32'h0));
            apb(1'h1, SETA[i], 32'hffffffff);
            apb(1'h1, SETA[i], 32'h0);
            apb(1'h1, CLRA[i], 32'h0);
            apb(1'h0, s, 32'h0);
            check("set", rd, fix(i, 32'hffffffff));
            apb(1'h1, CLRA[i], 32'h0000ffff);
            apb(1'h0, s, 32'h0);
            check("clear", rd, fix(i, 32'hffff0000));
            apb(1'h1, CLRA[i], 32'hffffffff);
        end
        apb(1'h1, 8'h0c, 32'hffffffff);
        apb(1'h0, 8'h0c, 32'h0);
        check("reserved", rd, 32'h0);
    endtask
    task automatic t_direct;
        apb(1'h1, 8'ha0, 32'h000000ff);
        apb(1'h1, 8'h38, 32'h0f0f0f0f);
        apb(1'h1, 8'ha4, 32'hffffffff);
        apb(1'h1, 8'h38, 32'hffffffff);
        apb(1'h0, 8'h38, 32'h0);
        check("direct", rd, 32'h0000000f);
    endtask
    task automatic t_route;
        apb(1'h0, 8'h4c, 32'h0);
        check("route a", {30'h0, pin_oe[2], pin_out[2]}, 32'h3);
        apb(1'h1, 8'h74, 32'h00000004);
        repeat (3) @(posedge clk);
        check("route b", {30'h0, pin_oe[2], pin_out[2]}, 32'h2);
        apb(1'h0, 8'h3c, 32'h0);
        check("levels", rd, 32'h00555551);
        apb(1'h0, 8'h4c, 32'h0);
        check("periph change", rd, 32'h00000004);
    endtask
    task automatic t_irq;
        apb(1'h1, 8'h40, 32'h02000000);
        apb(1'h0, 8'h4c, 32'h0);
        ext_lvl <= 32'h02000000;
        repeat (4) @(posedge clk);
        check("irq up", {31'h0, irq}, 32'h1);
        apb(1'h0, 8'h4c, 32'h0);
        check("status", rd, 32'h02000000);
        apb(1'h0, 8'h4c, 32'h0);
        check("status again", rd, 32'h0);
        check("irq down", {31'h0, irq}, 32'h0);
        apb(1'h1, 8'h44, 32'h02000000);
        ext_lvl <= 32'h0;
        repeat (4) @(posedge clk);
        check("masked", {31'h0, irq}, 32'h0);
    endtask
    task automatic t_filter;
        apb(1'h1, 8'h20, 32'h04000000);
        apb(1'h0, 8'h4c, 32'h0);
        pad.pulse(32'h0c000000, 10);
        repeat (5) @(posedge clk);
        apb(1'h0, 8'h4c, 32'h0);
        check("short", rd, 32'h08000000);
        pad.pulse(32'h04000000, 60);
        repeat (5) @(posedge clk);
        apb(1'h0, 8'h4c, 32'h0);
        check("long", rd, 32'h04000000);
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        apb(1'h0, 8'h4c, 32'h0);
        check("status reset", rd, 32'h0);
        t_pairs();
        t_direct();
        t_route();
        t_irq();
        t_filter();
        wrap_up();
    end
endmodule
`default_nettype wire
